/* File: logic/dds_status_drive.sv */
// drive end of the status exchange: builds the 16-bit status word from the
// mechanism and write path, keeps sticky errors and answers status requests
// assumes all inputs synchronous to ref_clk; the serial link is outside
//
// Notes on behaviour
// RULE1 - phase code in bits 0-2, loading through unloading heads
// RULE2 - bit 3 set while brushes are parked off the disk
// RULE3 - bit 4 set while heads are over the disk
// RULE4 - bit 5 set while cover is open or dust cover missing
// RULE5 - bit 6 gives selected head, one lower, zero upper
// RULE6 - bit 7 gives model, zero small drive, one large drive
// RULE7 - bit 8 flags more than one drive selected
// RULE8 - bit 9 set each time the drive enters head loading
// RULE9 - controller treats media change flag as a drive error
// RULE10 - bit 10 flags write gate while not ready, in sector, or protected
// RULE11 - bit 11 flags spindle too slow to spin up or overspeed
// RULE12 - bit 12 flags seek that fails to settle in time
// RULE13 - bit 13 gives write protection, one protected
// RULE14 - bit 14 flags write current without write gate
// RULE15 - bit 15 flags write gate with no write data transitions
// RULE16 - controller stores returned word for reading at the multipurpose port
// RULE17 - request with reset bit clears soft errors before the word is sent
// RULE18 - all sixteen status bits are captured together as one word
`timescale 1ns/1ps
`include "dds_status_defines.svh"

module dds_status_drive #(
  parameter int unsigned CNT_W = 24,
  parameter int unsigned SPIN_LIMIT_CYC = `DDS_SPIN_LIMIT_US * `DDS_CLK_MHZ,
  parameter int unsigned SEEK_LIMIT_CYC = `DDS_SEEK_LIMIT_US * `DDS_CLK_MHZ,
  parameter int unsigned WDATA_GAP_CYC = `DDS_WDATA_GAP_US * `DDS_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] drive_phase,
  input wire logic brushes_parked,
  input wire logic heads_loaded,
  input wire logic lid_ajar,
  input wire logic surface_pick,
  input wire logic drive_model_bit,
  input wire logic write_protected,
  input wire logic multi_select_seen,
  input wire logic drive_ready,
  input wire logic sector_pulse,
  input wire logic write_gate,
  input wire logic write_current_sense,
  input wire logic write_data_edge,
  input wire logic spindle_overspeed,
  input wire logic on_track,
  input wire logic status_req,
  input wire logic status_req_reset,
  output logic status_req_ready,
  output logic [15:0] status_word,
  output logic status_valid,
  output logic [`DDS_ERR_COUNT-1:0] soft_errors,
  output logic drive_error
);

  dds_status_pkg::dds_state_t state_reg;
  dds_status_pkg::dds_state_t state_next;
  dds_status_pkg::dds_phase_t phase;
  logic [2:0] phase_prev_reg;
  logic [CNT_W-1:0] spin_cnt_reg;
  logic [CNT_W-1:0] seek_cnt_reg;
  logic [CNT_W-1:0] gap_cnt_reg;
  logic [15:0] status_word_reg;
  logic status_valid_reg;
  logic drive_error_reg;
  logic in_seek;
  logic spin_late;
  logic seek_late;
  logic gap_late;
  logic [15:0] live_word;
  logic [`DDS_ERR_COUNT-1:0] err_events;

  dds_err_if err ();

  // counts up while run is high, holds at limit, restarts when run drops
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic [CNT_W-1:0] cnt,
    input logic run,
    input int unsigned limit
  );
    logic [CNT_W-1:0] lim;
    lim = limit[CNT_W-1:0];
    if (!run) begin
      cnt_step = '0;
    end else if (cnt >= lim) begin
      cnt_step = lim;
    end else begin
      cnt_step = cnt + 1'b1;
    end
  endfunction

  function automatic logic cnt_hit(
    input logic [CNT_W-1:0] cnt,
    input int unsigned limit
  );
    cnt_hit = (cnt >= limit[CNT_W-1:0]);
  endfunction

  assign phase = dds_status_pkg::dds_phase_t'(drive_phase);
  assign in_seek = (phase == dds_status_pkg::DDS_PH_SEEK_COUNT)
    || (phase == dds_status_pkg::DDS_PH_SEEK_LOCK);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_prev_reg <= 3'h0;
    end else begin
      phase_prev_reg <= drive_phase;
    end
  end

  // spin-up watchdog
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      spin_cnt_reg <= '0;
    end else begin
      spin_cnt_reg <= cnt_step(spin_cnt_reg,
        phase == dds_status_pkg::DDS_PH_SPIN_UP, SPIN_LIMIT_CYC); // see RULE11
    end
  end

  // settle watchdog; clears to zero once the heads are on track
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seek_cnt_reg <= '0;
    end else begin
      seek_cnt_reg <= cnt_step(seek_cnt_reg, in_seek && !on_track,
        SEEK_LIMIT_CYC); // see RULE12
    end
  end

  // gap since the last write data transition while write gate is on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_cnt_reg <= '0;
    end else begin
      gap_cnt_reg <= cnt_step(gap_cnt_reg, write_gate && !write_data_edge,
        WDATA_GAP_CYC); // see RULE15
    end
  end

  assign spin_late = cnt_hit(spin_cnt_reg, SPIN_LIMIT_CYC);
  assign seek_late = cnt_hit(seek_cnt_reg, SEEK_LIMIT_CYC);
  assign gap_late = cnt_hit(gap_cnt_reg, WDATA_GAP_CYC);

  always_comb begin
    err_events = '0;
    err_events[`DDS_ERR_MULTI_SELECT] = multi_select_seen; // see RULE7
    err_events[`DDS_ERR_MEDIA_CHANGE] = (phase == dds_status_pkg::DDS_PH_LOAD_HEADS)
      && (phase_prev_reg != drive_phase); // see RULE8
    err_events[`DDS_ERR_WRITE_MISUSE] = write_gate
      && (!drive_ready || sector_pulse || write_protected); // see RULE10
    err_events[`DDS_ERR_SPINDLE] = spin_late || spindle_overspeed; // see RULE11
    err_events[`DDS_ERR_POSITION] = seek_late; // see RULE12
    err_events[`DDS_ERR_STRAY_CURRENT] = write_current_sense && !write_gate; // see RULE14
    err_events[`DDS_ERR_MISSING_PULSES] = write_gate && gap_late; // see RULE15
  end

  assign err.set_vec = err_events;
  assign err.clear = (state_reg == dds_status_pkg::DDS_ST_CLEAR); // see RULE17

  dds_err_reg u_err (
    .ref_clk(ref_clk),
    .rst(rst),
    .err(err.store)
  );

  always_comb begin
    live_word = `DDS_STATUS_RESET;
    live_word[`DDS_BIT_PHASE_HI:`DDS_BIT_PHASE_LO] = drive_phase; // see RULE1
    live_word[`DDS_BIT_BRUSHES_PARKED] = brushes_parked; // see RULE2
    live_word[`DDS_BIT_HEADS_LOADED] = heads_loaded; // see RULE3
    live_word[`DDS_BIT_LID_AJAR] = lid_ajar; // see RULE4
    live_word[`DDS_BIT_SURFACE_PICK] = surface_pick; // see RULE5
    live_word[`DDS_BIT_DRIVE_MODEL] = drive_model_bit; // see RULE6
    live_word[`DDS_BIT_MULTI_SELECT] = err.flags[`DDS_ERR_MULTI_SELECT];
    live_word[`DDS_BIT_MEDIA_CHANGE] = err.flags[`DDS_ERR_MEDIA_CHANGE];
    live_word[`DDS_BIT_WRITE_MISUSE] = err.flags[`DDS_ERR_WRITE_MISUSE];
    live_word[`DDS_BIT_SPINDLE_FAULT] = err.flags[`DDS_ERR_SPINDLE];
    live_word[`DDS_BIT_POSITION_TIMEOUT] = err.flags[`DDS_ERR_POSITION];
    live_word[`DDS_BIT_WRITE_PROTECTED] = write_protected; // see RULE13
    live_word[`DDS_BIT_STRAY_CURRENT] = err.flags[`DDS_ERR_STRAY_CURRENT];
    live_word[`DDS_BIT_MISSING_PULSES] = err.flags[`DDS_ERR_MISSING_PULSES];
  end

  // request sequencer: optional soft clear, then one snapshot
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dds_status_pkg::DDS_ST_IDLE: begin
        if (status_req) begin
          state_next = status_req_reset ? dds_status_pkg::DDS_ST_CLEAR
            : dds_status_pkg::DDS_ST_SEND; // see RULE17
        end
      end
      dds_status_pkg::DDS_ST_CLEAR: begin
        state_next = dds_status_pkg::DDS_ST_SEND;
      end
      dds_status_pkg::DDS_ST_SEND: begin
        state_next = dds_status_pkg::DDS_ST_IDLE;
      end
      default: begin
        state_next = dds_status_pkg::DDS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= dds_status_pkg::DDS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // whole word taken in one edge so no flag mix can reach the controller
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_word_reg <= `DDS_STATUS_RESET;
      status_valid_reg <= 1'b0;
      drive_error_reg <= 1'b0;
    end else begin
      status_valid_reg <= (state_reg == dds_status_pkg::DDS_ST_SEND);
      if (state_reg == dds_status_pkg::DDS_ST_SEND) begin
        status_word_reg <= live_word; // see RULE16 RULE18
        // media change counts too, so software learns it must recheck the volume
        drive_error_reg <= |err.flags; // see RULE9
      end
    end
  end

  assign status_req_ready = (state_reg == dds_status_pkg::DDS_ST_IDLE);
  assign status_word = status_word_reg;
  assign status_valid = status_valid_reg;
  assign soft_errors = err.flags;
  assign drive_error = drive_error_reg;

endmodule

/* File: logic/dds_status_defines.svh */
// status word bit positions, error indices and timing figures for the drive status block
// assumes a single 100 MHz clock; included by bare name from logic/
`ifndef DDS_STATUS_DEFINES_SVH
`define DDS_STATUS_DEFINES_SVH

`define DDS_CLK_MHZ 100

`define DDS_BIT_PHASE_LO 0
`define DDS_BIT_PHASE_HI 2
`define DDS_BIT_BRUSHES_PARKED 3
`define DDS_BIT_HEADS_LOADED 4
`define DDS_BIT_LID_AJAR 5
`define DDS_BIT_SURFACE_PICK 6
`define DDS_BIT_DRIVE_MODEL 7
`define DDS_BIT_MULTI_SELECT 8
`define DDS_BIT_MEDIA_CHANGE 9
`define DDS_BIT_WRITE_MISUSE 10
`define DDS_BIT_SPINDLE_FAULT 11
`define DDS_BIT_POSITION_TIMEOUT 12
`define DDS_BIT_WRITE_PROTECTED 13
`define DDS_BIT_STRAY_CURRENT 14
`define DDS_BIT_MISSING_PULSES 15

// index of each sticky error inside the error register
`define DDS_ERR_MULTI_SELECT 0
`define DDS_ERR_MEDIA_CHANGE 1
`define DDS_ERR_WRITE_MISUSE 2
`define DDS_ERR_SPINDLE 3
`define DDS_ERR_POSITION 4
`define DDS_ERR_STRAY_CURRENT 5
`define DDS_ERR_MISSING_PULSES 6
`define DDS_ERR_COUNT 7

`define DDS_STATUS_RESET 16'h0000
`define DDS_ERR_RESET 7'h00

// time limits in microseconds; cycle counts derive from them in the top module
`define DDS_SPIN_LIMIT_US 100000
`define DDS_SEEK_LIMIT_US 100
`define DDS_WDATA_GAP_US 2

`endif

/* File: logic/dds_status_pkg.sv */
// types shared by the drive status block
// assumes dds_status_defines.svh holds the numeric constants
package dds_status_pkg;

  typedef enum logic [2:0] {
    DDS_PH_LOADING = 3'b000,
    DDS_PH_SPIN_UP = 3'b001,
    DDS_PH_BRUSH = 3'b010,
    DDS_PH_LOAD_HEADS = 3'b011,
    DDS_PH_SEEK_COUNT = 3'b100,
    DDS_PH_SEEK_LOCK = 3'b101,
    DDS_PH_UNLOAD_HEADS = 3'b110,
    DDS_PH_UNUSED = 3'b111
  } dds_phase_t;

  typedef enum logic [1:0] {
    DDS_ST_IDLE = 2'b00,
    DDS_ST_CLEAR = 2'b01,
    DDS_ST_SEND = 2'b10
  } dds_state_t;

endpackage

/* File: logic/dds_err_if.sv */
// carries error events, the soft clear and the sticky flags between the
// status top and its error register
// assumes one clock domain
`timescale 1ns/1ps
`include "dds_status_defines.svh"

interface dds_err_if;
  logic [`DDS_ERR_COUNT-1:0] set_vec;
  logic clear;
  logic [`DDS_ERR_COUNT-1:0] flags;

  modport src (
    output set_vec,
    output clear,
    input flags
  );

  modport store (
    input set_vec,
    input clear,
    output flags
  );
endinterface

/* File: logic/dds_err_reg.sv */
// sticky soft error register of the drive
// assumes set and clear arrive synchronous to ref_clk
`timescale 1ns/1ps
`include "dds_status_defines.svh"

module dds_err_reg (
  input wire logic ref_clk,
  input wire logic rst,
  dds_err_if.store err
);

  logic [`DDS_ERR_COUNT-1:0] flags_reg;
  logic [`DDS_ERR_COUNT-1:0] flags_next;

  // an event in the clearing cycle survives: set wins over clear
  always_comb begin
    flags_next = err.clear ? err.set_vec : (flags_reg | err.set_vec); // see RULE17
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= `DDS_ERR_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign err.flags = flags_reg;

endmodule

/* File: test/dds_status_assertions.sv */
// port assertions for the drive status block
// assumes it is bound onto dds_status_drive; one clock, async reset
`timescale 1ns/1ps
`include "dds_status_defines.svh"
module dds_status_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] drive_phase,
  input wire logic write_protected,
  input wire logic multi_select_seen,
  input wire logic drive_ready,
  input wire logic sector_pulse,
  input wire logic write_gate,
  input wire logic write_current_sense,
  input wire logic status_req,
  input wire logic status_req_reset,
  input wire logic status_req_ready,
  input wire logic [15:0] status_word,
  input wire logic status_valid,
  input wire logic [`DDS_ERR_COUNT-1:0] soft_errors,
  input wire logic drive_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic take = status_req && status_req_ready;
  a_multi_select_set: assert property (multi_select_seen |=> soft_errors[0])
    else $error("multi select not flagged");
  a_media_change_set: assert property (
    drive_phase == 3'b011 && $past(drive_phase) != 3'b011 |=> soft_errors[1])
    else $error("head load entry not flagged");
  a_write_misuse_set: assert property (
    write_gate && (!drive_ready || sector_pulse || write_protected) |=> soft_errors[2])
    else $error("write gate misuse not flagged");
  a_stray_current_set: assert property (
    write_current_sense && !write_gate |=> soft_errors[5])
    else $error("stray current not flagged");
  a_plain_answer: assert property (
    take && !status_req_reset |=> !status_req_ready ##1 status_valid)
    else $error("plain request answer late");
  a_reset_answer: assert property (
    take && status_req_reset |=> !status_valid [*2] ##1 status_valid)
    else $error("reset request answer late");
  a_errors_cleared: assert property (
    take && status_req_reset ##1 (!multi_select_seen && !write_gate && !write_current_sense
    && drive_phase == 3'b000) |=> soft_errors[2:0] == 3'b000 && !soft_errors[5])
    else $error("soft errors survive clear");
  a_level_copied: assert property (
    status_valid |-> status_word[2:0] == $past(drive_phase)
    && status_word[13] == $past(write_protected))
    else $error("live bits not captured");
  a_error_summary: assert property (
    status_valid |-> drive_error == (|{status_word[15:14], status_word[12:8]}))
    else $error("drive error summary wrong");
  c_reset_req: cover property (take && status_req_reset);
  c_media_word: cover property (status_valid && status_word[9]);
  c_gap_error: cover property (soft_errors[6]);
endmodule
bind dds_status_drive dds_status_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
  .drive_phase(drive_phase), .write_protected(write_protected),
  .multi_select_seen(multi_select_seen), .drive_ready(drive_ready),
  .sector_pulse(sector_pulse), .write_gate(write_gate),
  .write_current_sense(write_current_sense), .status_req(status_req),
  .status_req_reset(status_req_reset), .status_req_ready(status_req_ready),
  .status_word(status_word), .status_valid(status_valid), .soft_errors(soft_errors),
  .drive_error(drive_error));

/* File: test/dds_ctrl_model.sv */
// controller model: issues status requests and keeps the returned word
// assumes go is a one-cycle strobe from the bench
`timescale 1ns/1ps
module dds_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic go_reset,
  input wire logic status_req_ready,
  input wire logic [15:0] status_word,
  input wire logic status_valid,
  output logic status_req,
  output logic status_req_reset,
  output logic [15:0] multipurpose_port
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_req <= 1'b0;
      status_req_reset <= 1'b0;
      multipurpose_port <= 16'h0000;
    end else begin
      if (go) begin
        status_req <= 1'b1;
        status_req_reset <= go_reset;
      end else if (status_req && status_req_ready) begin
        status_req <= 1'b0;
        // reset line flips to the opposite of its last value
        status_req_reset <= ~status_req_reset;
      end
      if (status_valid) begin
        multipurpose_port <= status_word;
      end
    end
  end
endmodule

/* File: test/dds_status_drive_tb.sv */
// bench for the drive status block with a controller model
// assumes shortened time limits set through the top parameters
`timescale 1ns/1ps
module dds_status_drive_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [16:0] iv = 17'h1_0400;
  logic go = 1'b0;
  logic go_reset = 1'b0;
  logic status_req, status_req_reset, status_req_ready, status_valid, drive_error;
  logic [15:0] status_word, multipurpose_port;
  logic [6:0] soft_errors;
  logic [16:0] cz [0:11];
  int hz [0:11];
  logic [15:0] ez [0:11];
  int k;
  int n_errors = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  dds_status_drive #(.SPIN_LIMIT_CYC(20), .SEEK_LIMIT_CYC(10), .WDATA_GAP_CYC(5)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .drive_phase(iv[2:0]), .brushes_parked(iv[3]),
    .heads_loaded(iv[4]), .lid_ajar(iv[5]), .surface_pick(iv[6]), .drive_model_bit(iv[7]),
    .write_protected(iv[8]), .multi_select_seen(iv[9]), .drive_ready(iv[10]),
    .sector_pulse(iv[11]), .write_gate(iv[12]), .write_current_sense(iv[13]),
    .write_data_edge(iv[14]), .spindle_overspeed(iv[15]), .on_track(iv[16]),
    .status_req(status_req), .status_req_reset(status_req_reset),
    .status_req_ready(status_req_ready), .status_word(status_word),
    .status_valid(status_valid), .soft_errors(soft_errors), .drive_error(drive_error));
  dds_ctrl_model u_ctrl (.ref_clk(ref_clk), .rst(rst), .go(go), .go_reset(go_reset),
    .status_req_ready(status_req_ready), .status_word(status_word),
    .status_valid(status_valid), .status_req(status_req),
    .status_req_reset(status_req_reset), .multipurpose_port(multipurpose_port));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // cause held n cycles, then back to a quiet ready drive
  task hold(input logic [16:0] v, input int n);
    iv = v;
    repeat (n) @(posedge ref_clk);
    #1;
    iv = 17'h1_0400;
  endtask
  task get_status(input logic r);
    int i;
    go = 1'b1;
    go_reset = r;
    @(posedge ref_clk);
    #1;
    go = 1'b0;
    for (i = 0; i < 10 && status_valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({15'h0000, status_valid}, 16'h0001);
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
  initial begin
    cz = '{17'h1_0600, 17'h1_1000, 17'h1_1C00, 17'h1_1500, 17'h1_2400, 17'h1_8400,
      17'h1_0401, 17'h1_0401, 17'h0_0404, 17'h0_0404, 17'h1_1400, 17'h1_5400};
    hz = '{1, 1, 1, 1, 1, 1, 25, 12, 15, 5, 12, 12};
    ez = '{16'h0100, 16'h0400, 16'h0400, 16'h0400, 16'h4000, 16'h0800,
      16'h0800, 16'h0000, 16'h1000, 16'h0000, 16'h8000, 16'h0000};
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({15'h0000, status_req_ready}, 16'h0001);
    chk(status_word, 16'h0000);
    for (k = 0; k < 7; k++) begin
      iv = {8'h82, k[0], 5'h15 ^ 5'(k), k[2:0]};
      get_status(1'b0);
      chk(multipurpose_port, {2'b00, k[0], 3'b000, k >= 3, 1'b0, 5'h15 ^ 5'(k), k[2:0]});
      chk({15'h0000, drive_error}, {15'h0000, k >= 3});
    end
    iv = 17'h1_0400;
    get_status(1'b1);
    chk(multipurpose_port, 16'h0000);
    chk({9'h000, soft_errors}, 16'h0000);
    for (k = 0; k < 12; k++) begin
      hold(cz[k], hz[k]);
      get_status(1'b0);
      chk(multipurpose_port, ez[k]);
      chk({15'h0000, drive_error}, {15'h0000, ez[k] != 16'h0000});
      get_status(1'b1);
      chk(multipurpose_port, 16'h0000);
    end
    // mid-run reset must drop a fresh sticky error and the last snapshot
    hold(17'h1_0600, 1);
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({9'h000, soft_errors}, 16'h0000);
    chk(status_word, 16'h0000);
    chk({15'h0000, drive_error}, 16'h0000);
    get_status(1'b0);
    chk(multipurpose_port, 16'h0000);
    summarize;
  end
endmodule
